// [logic/prf_defines.vh]
// constants for the paged register file address decoder
// assumes inclusion by the decoder files only; definitions only
`ifndef PRF_DEFINES_VH
`define PRF_DEFINES_VH

`define PRF_OFS_SLICE_A 8'hd6
`define PRF_OFS_SLICE_B 8'hd7
`define PRF_OFS_PAGE 8'hdf
`define PRF_RST_PAGE 8'h00
`define PRF_RST_SLICE_A 8'hc0
`define PRF_RST_SLICE_B 8'hc8
`define PRF_SET1_BASE 2'h3
`define PRF_BANK_HI 3'h7
`define PRF_COMMON_HI 4'hc
`define PRF_WR_PREFIX 4'hc
`define PRF_DISPLAY_PAGE 4'hf
`define PRF_PAGE_SRC_LSB 0
`define PRF_PAGE_DST_LSB 4
`define PRF_MODE_REG 3'h0
`define PRF_MODE_WR4 3'h1
`define PRF_MODE_IND 3'h2
`define PRF_MODE_IDX 3'h3
`define PRF_MODE_OTHER 3'h4
`define PRF_AREA_PRIME 3'h0
`define PRF_AREA_SET1 3'h1
`define PRF_AREA_SET1_BANK 3'h2
`define PRF_AREA_SET2 3'h3
`define PRF_AREA_BAD 3'h4

`endif

// [logic/prf_slice_map.v]
// working register field to full address mapping
// assumes both slice pointers come from registers on the same clock
`timescale 1ns/1ps
module prf_slice_map (
  input wire [3:0] i_field,
  input wire [7:0] i_slice_a,
  input wire [7:0] i_slice_b,
  output wire [7:0] o_addr
);
  // bit 3 picks the pointer; pointer top five bits plus field low three
  assign o_addr = i_field[3] ? {i_slice_b[7:3], i_field[2:0]} :
                  {i_slice_a[7:3], i_field[2:0]};
endmodule

// [logic/prf_decoder.v]
// paged register file address decoder with its pointer registers
// assumes a core-side register bus on i_clk; storage lives outside
//
// Function
// - page pointer at dfh selects one of up to 16 pages
// - reset clears both page nibbles to page 0
// - display data pages reached only by changing the page pointer
// - c0h-ffh is set 1, reachable on every page
// - e0h-ffh backed by two banks chosen by bank instructions
// - reset selects bank 0
// - d0h-dfh system registers, c0h-cfh common area, banks hold peripherals
// - common area c0h-cfh only via working-register addressing
// - plain register addressing of d0h-ffh always reaches set 1
// - set 2 overlays c0h-ffh, reached by indirect or indexed modes
// - set 2 exists on pages 0-9, 0-3 or 0-1 by variant
// - 00h-bfh of each page is prime area, all modes allowed
// - page 0 prime area usable right after reset
// - file seen as 32 slices of eight registers
// - slice chosen by five upper address bits
// - two slice pointers at d6h and d7h form the working block
// - reset points slices at c0h-c7h and c8h-cfh
// - slice pointers written by set-pointer or load instructions
// - working-register addressing never reaches set 2
// - each slice pointer addresses any slice independently
// - field bit 3 picks pointer; upper five plus low three bits
// - 8-bit address with upper nibble 1100b is working addressing
// - register pair: even address holds msb, odd holds lsb
`timescale 1ns/1ps
`include "prf_defines.vh"
module prf_decoder #(
  parameter PAGE_COUNT = 10,
  parameter SET2_PAGES = 10
) (
  input wire i_clk,
  input wire i_resetn,
  // core request: address, mode, direction, pair access
  input wire i_req,
  input wire [7:0] i_addr,
  input wire [2:0] i_mode,
  input wire i_write,
  input wire i_pair,
  input wire [7:0] i_wdata,
  // pointer instructions
  input wire i_sel_bank_zero,
  input wire i_sel_bank_one,
  input wire i_set_slice_a,
  input wire i_set_slice_b,
  input wire [7:0] i_slice_value,
  // decoded answer
  output reg o_valid,
  output reg o_invalid,
  output reg [2:0] o_area,
  output reg [3:0] o_page,
  output reg o_bank,
  output reg [7:0] o_phys_addr,
  output reg [7:0] o_phys_addr_lo,
  output reg [7:0] o_rdata,
  output reg o_rdata_hit,
  // pointer state for the core
  output wire [7:0] o_page_select_pointer,
  output wire [7:0] o_working_slice_pointer_a,
  output wire [7:0] o_working_slice_pointer_b,
  output wire o_bank_sel
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function is_set1;
    input [7:0] a;
    begin
      is_set1 = (a[7:6] == `PRF_SET1_BASE);
    end
  endfunction

  function is_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_hit = (a == ofs);
    end
  endfunction

  // prime area exists on the general pages and on the display page
  function prime_page_ok;
    input [3:0] p;
    begin
      prime_page_ok = ({1'b0, p} < PAGE_COUNT[4:0]) ||
                      (p == `PRF_DISPLAY_PAGE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pointer registers

  reg [7:0] page_select_pointer_reg;
  reg [7:0] working_slice_pointer_a_reg;
  reg [7:0] working_slice_pointer_b_reg;
  reg bank_reg;
  reg [7:0] page_select_pointer_next;
  reg [7:0] working_slice_pointer_a_next;
  reg [7:0] working_slice_pointer_b_next;
  reg bank_next;

  wire [7:0] wr_addr;
  wire [7:0] eff_addr;
  wire wr_mode;
  wire reg_write;
  wire ptr_access;

  // 8-bit address with prefix 1100b behaves as a 4-bit working field,
  // so a register-mode c0h-cfh address reaches the common area only through the slice pointers
  assign wr_mode = (i_mode == `PRF_MODE_WR4) ||
                   ((i_mode == `PRF_MODE_REG) &&
                    (i_addr[7:4] == `PRF_WR_PREFIX));

  prf_slice_map u_map (
    .i_field(i_addr[3:0]),
    .i_slice_a(working_slice_pointer_a_reg),
    .i_slice_b(working_slice_pointer_b_reg),
    .o_addr(wr_addr)
  );

  assign eff_addr = wr_mode ? wr_addr : i_addr;
  // pointer registers sit in set 1, so only set 1 style accesses hit them
  assign ptr_access = wr_mode || (i_mode == `PRF_MODE_REG);
  assign reg_write = i_req && i_write && ptr_access;

  always @* begin
    page_select_pointer_next = page_select_pointer_reg;
    working_slice_pointer_a_next = working_slice_pointer_a_reg;
    working_slice_pointer_b_next = working_slice_pointer_b_reg;
    bank_next = bank_reg;
    if (i_sel_bank_zero) begin
      bank_next = 1'b0;
    end else if (i_sel_bank_one) begin
      bank_next = 1'b1;
    end
    if (reg_write && is_hit(eff_addr, `PRF_OFS_PAGE)) begin
      page_select_pointer_next = i_wdata;
    end
    if (reg_write && is_hit(eff_addr, `PRF_OFS_SLICE_A)) begin
      working_slice_pointer_a_next = i_wdata;
    end
    if (reg_write && is_hit(eff_addr, `PRF_OFS_SLICE_B)) begin
      working_slice_pointer_b_next = i_wdata;
    end
    // set-pointer instruction wins over a same-cycle load
    if (i_set_slice_a) begin
      working_slice_pointer_a_next = i_slice_value;
    end
    if (i_set_slice_b) begin
      working_slice_pointer_b_next = i_slice_value;
    end
  end

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      page_select_pointer_reg <= `PRF_RST_PAGE;
      working_slice_pointer_a_reg <= `PRF_RST_SLICE_A;
      working_slice_pointer_b_reg <= `PRF_RST_SLICE_B;
      bank_reg <= 1'b0;
    end else begin
      page_select_pointer_reg <= page_select_pointer_next;
      working_slice_pointer_a_reg <= working_slice_pointer_a_next;
      working_slice_pointer_b_reg <= working_slice_pointer_b_next;
      bank_reg <= bank_next;
    end
  end

  assign o_page_select_pointer = page_select_pointer_reg;
  assign o_working_slice_pointer_a = working_slice_pointer_a_reg;
  assign o_working_slice_pointer_b = working_slice_pointer_b_reg;
  assign o_bank_sel = bank_reg;

  ////////////////////////////////////////////////////////////////////////
  // area classification

  reg [2:0] area_c;
  reg bad_c;
  reg [3:0] page_c;
  reg [7:0] addr_c;

  always @* begin
    area_c = `PRF_AREA_PRIME;
    bad_c = 1'b0;
    addr_c = eff_addr;
    // reads page by source nibble, writes by destination nibble
    page_c = i_write ? page_select_pointer_reg[`PRF_PAGE_DST_LSB +: 4] :
             page_select_pointer_reg[`PRF_PAGE_SRC_LSB +: 4];
    if (i_pair) begin
      addr_c = {eff_addr[7:1], 1'b0};
    end
    if (!is_set1(addr_c)) begin
      area_c = `PRF_AREA_PRIME;
      // only pages that exist hold a prime area
      if (!prime_page_ok(page_c)) begin
        bad_c = 1'b1;
      end
    end else begin
      case (i_mode)
        `PRF_MODE_REG, `PRF_MODE_WR4: begin
          // working addressing never reaches set 2; set 1 ignores the page
          area_c = (addr_c[7:5] == `PRF_BANK_HI) ?
                   `PRF_AREA_SET1_BANK : `PRF_AREA_SET1;
        end
        `PRF_MODE_IND, `PRF_MODE_IDX: begin
          area_c = `PRF_AREA_SET2;
          if ({1'b0, page_c} >= SET2_PAGES[4:0]) begin
            bad_c = 1'b1;
          end
        end
        default: begin
          // other modes cannot reach either upper set
          area_c = `PRF_AREA_BAD;
          bad_c = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered answer, one cycle after the request

  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_valid <= 1'b0;
      o_invalid <= 1'b0;
      o_area <= `PRF_AREA_PRIME;
      o_page <= 4'h0;
      o_bank <= 1'b0;
      o_phys_addr <= 8'h00;
      o_phys_addr_lo <= 8'h00;
      o_rdata <= 8'h00;
      o_rdata_hit <= 1'b0;
    end else begin
      o_valid <= i_req;
      o_invalid <= i_req && bad_c;
      o_area <= area_c;
      // set 1 is page independent, so report page 0 for it
      o_page <= (area_c == `PRF_AREA_SET1 ||
                 area_c == `PRF_AREA_SET1_BANK) ? 4'h0 : page_c;
      o_bank <= bank_reg;
      o_phys_addr <= addr_c;
      o_phys_addr_lo <= {addr_c[7:1], 1'b1};
      // pointer reads use the same access modes as pointer writes
      o_rdata_hit <= i_req && !i_write && ptr_access &&
                     (is_hit(addr_c, `PRF_OFS_PAGE) ||
                      is_hit(addr_c, `PRF_OFS_SLICE_A) ||
                      is_hit(addr_c, `PRF_OFS_SLICE_B));
      if (is_hit(addr_c, `PRF_OFS_PAGE)) begin
        o_rdata <= page_select_pointer_reg;
      end else if (is_hit(addr_c, `PRF_OFS_SLICE_A)) begin
        o_rdata <= working_slice_pointer_a_reg;
      end else if (is_hit(addr_c, `PRF_OFS_SLICE_B)) begin
        o_rdata <= working_slice_pointer_b_reg;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

endmodule

// [verif/prf_decoder_monitor.sv]
// concurrent checks on the decoder ports
// assumes one clock with a synchronous active-low reset
`timescale 1ns/1ps
module prf_decoder_monitor (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_req,
  input wire logic [7:0] i_addr,
  input wire logic [2:0] i_mode,
  input wire logic i_pair,
  input wire logic i_sel_bank_zero,
  input wire logic i_sel_bank_one,
  input wire logic i_set_slice_a,
  input wire logic [7:0] i_slice_value,
  input wire logic [2:0] o_area,
  input wire logic [7:0] o_phys_addr,
  input wire logic [7:0] o_page_select_pointer,
  input wire logic [7:0] o_working_slice_pointer_a,
  input wire logic [7:0] o_working_slice_pointer_b,
  input wire logic o_bank_sel
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // pointer picked by field bit 3, value before any same-cycle write
  wire logic [7:0] sel = i_addr[3] ? o_working_slice_pointer_b :
    o_working_slice_pointer_a;
  wire logic hi = i_req && i_addr[7:6] == 2'h3;
////////////////////////////////////////////////////////////////////////////
  property p_rst;
    $rose(i_resetn) |-> o_page_select_pointer == 8'h00 && !o_bank_sel &&
      o_working_slice_pointer_a == 8'hc0 && o_working_slice_pointer_b == 8'hc8;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  // a pair access lands on the even address
  property p_wr4;
    i_req && i_mode == 3'h1 |=>
      o_phys_addr == {$past(sel[7:3]), $past(i_addr[2:1]),
        $past(i_addr[0]) && !$past(i_pair)};
  endproperty
  a_wr4: assert property (p_wr4) else $error("wr4 addr");
  property p_wr8;
    i_req && i_mode == 3'h0 && i_addr[7:4] == 4'hc |=>
      o_phys_addr == {$past(sel[7:3]), $past(i_addr[2:1]),
        $past(i_addr[0]) && !$past(i_pair)};
  endproperty
  a_wr8: assert property (p_wr8) else $error("wr8 addr");
  property p_nos2;
    i_req && i_mode == 3'h1 && sel[7:6] == 2'h3 |=> o_area != 3'h3;
  endproperty
  a_nos2: assert property (p_nos2) else $error("wr set2");
  property p_set2;
    hi && i_mode == 3'h2 && o_page_select_pointer == 8'h00 |=> o_area == 3'h3;
  endproperty
  a_set2: assert property (p_set2) else $error("set2");
  property p_set1;
    hi && i_mode == 3'h0 && i_addr[5:4] != 2'h0 |=>
      o_area == ($past(i_addr[5]) ? 3'h2 : 3'h1);
  endproperty
  a_set1: assert property (p_set1) else $error("set1");
  property p_bank;
    i_sel_bank_zero || i_sel_bank_one |=> o_bank_sel == !$past(i_sel_bank_zero);
  endproperty
  a_bank: assert property (p_bank) else $error("bank");
  property p_ptr;
    i_set_slice_a |=> o_working_slice_pointer_a == $past(i_slice_value);
  endproperty
  a_ptr: assert property (p_ptr) else $error("slice");
  c_wr4: cover property (i_req && i_mode == 3'h1);
  c_bank: cover property (i_sel_bank_one);
  c_set2: cover property (hi && i_mode == 3'h2);
endmodule
////////////////////////////////////////////////////////////////////////////
bind prf_decoder prf_decoder_monitor mon (.i_clk, .i_resetn, .i_req, .i_addr,
  .i_mode, .i_pair, .i_sel_bank_zero, .i_sel_bank_one, .i_set_slice_a,
  .i_slice_value, .o_area, .o_phys_addr, .o_page_select_pointer,
  .o_working_slice_pointer_a, .o_working_slice_pointer_b, .o_bank_sel);

// [verif/prf_core_model.sv]
// core-side model: requests and pointer instructions
// assumes the bench gives the clock and calls go once per operation
`timescale 1ns/1ps
module prf_core_model (
  input wire logic i_clk,
  output logic [6:0] o_ctl,
  output logic [7:0] o_addr,
  output logic [2:0] o_mode,
  output logic [7:0] o_data
);
  // o_ctl: req, write, pair, bank zero, bank one, set a, set b
  initial begin
    o_ctl = 7'h00;
    o_addr = 8'h00;
    o_mode = 3'h0;
    o_data = 8'h00;
  end
  // held for one edge; then controls cleared, address and data inverted, mode kept
  task automatic go(input logic [6:0] c, input logic [7:0] a,
    input logic [2:0] m, input logic [7:0] d);
    @(posedge i_clk);
    o_ctl <= c;
    o_addr <= a;
    o_mode <= m;
    o_data <= d;
    @(posedge i_clk);
    o_ctl <= 7'h00;
    o_addr <= ~a;
    o_data <= ~d;
    #1;
  endtask
endmodule

// [verif/paged_register_file_addressing_test.sv]
// self-checking bench for the paged register file decoder
// assumes prf_core_model as the core and the bound monitor
`timescale 1ns/1ps
module paged_register_file_addressing_test;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [6:0] c;
  logic [7:0] a, d, pa, pl, pp, sa, sb, rd;
  logic [2:0] m, ar;
  logic [3:0] pg;
  logic v, bk, bs, iv, rh;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  // mode, address, area, final address
  logic [21:0] rows [9] = '{{3'h1, 8'h06, 3'h1, 8'hc6},
    {3'h1, 8'h0b, 3'h1, 8'hcb}, {3'h0, 8'hc5, 3'h1, 8'hc5},
    {3'h0, 8'hd0, 3'h1, 8'hd0}, {3'h0, 8'he4, 3'h2, 8'he4},
    {3'h2, 8'hc4, 3'h3, 8'hc4}, {3'h3, 8'hf0, 3'h3, 8'hf0},
    {3'h0, 8'h40, 3'h0, 8'h40}, {3'h4, 8'h10, 3'h0, 8'h10}};
  always #4 i_clk = ~i_clk;
  prf_core_model core (.i_clk(i_clk), .o_ctl(c), .o_addr(a), .o_mode(m),
    .o_data(d));
  prf_decoder dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(c[6]),
    .i_addr(a), .i_mode(m), .i_write(c[5]), .i_pair(c[4]), .i_wdata(d),
    .i_sel_bank_zero(c[3]), .i_sel_bank_one(c[2]), .i_set_slice_a(c[1]),
    .i_set_slice_b(c[0]), .i_slice_value(d), .o_valid(v), .o_invalid(iv),
    .o_area(ar), .o_page(pg), .o_bank(bk), .o_phys_addr(pa),
    .o_phys_addr_lo(pl), .o_rdata(rd), .o_rdata_hit(rh),
    .o_page_select_pointer(pp), .o_working_slice_pointer_a(sa),
    .o_working_slice_pointer_b(sb), .o_bank_sel(bs));
////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task conclude;
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // the run needs about 100 cycles; far more means a hang
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 500) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    chk(pp, 8'h00);
    chk(sa, 8'hc0);
    chk(sb, 8'hc8);
    chk({7'h0, bs}, 8'h00);
    foreach (rows[i]) begin
      core.go(7'h40, rows[i][18:11], rows[i][21:19], 8'h00);
      chk({7'h0, v}, 8'h01);
      chk({7'h0, iv}, 8'h00);
      chk({5'h0, ar}, {5'h0, rows[i][10:8]});
      chk(pa, rows[i][7:0]);
    end
    core.go(7'h60, 8'hdf, 3'h0, 8'h21);
    chk(pp, 8'h21);
    core.go(7'h40, 8'h40, 3'h0, 8'h00);
    chk({4'h0, pg}, 8'h01);
    core.go(7'h60, 8'h40, 3'h0, 8'h00);
    chk({4'h0, pg}, 8'h02);
    core.go(7'h04, 8'h00, 3'h0, 8'h00);
    core.go(7'h40, 8'he4, 3'h0, 8'h00);
    chk({5'h0, ar}, 8'h02);
    chk({7'h0, bk}, 8'h01);
    core.go(7'h08, 8'h00, 3'h0, 8'h00);
    chk({7'h0, bs}, 8'h00);
    core.go(7'h02, 8'h00, 3'h0, 8'h70);
    core.go(7'h60, 8'hd7, 3'h0, 8'h48);
    core.go(7'h40, 8'h06, 3'h1, 8'h00);
    chk(pa, 8'h76);
    core.go(7'h40, 8'h0f, 3'h1, 8'h00);
    chk(pa, 8'h4f);
    core.go(7'h02, 8'h00, 3'h0, 8'he0);
    core.go(7'h40, 8'h02, 3'h1, 8'h00);
    chk({5'h0, ar}, 8'h02);
    core.go(7'h50, 8'h40, 3'h0, 8'h00);
    chk(pa, 8'h40);
    chk(pl, 8'h41);
    // pointer read back, by register and by working addressing
    core.go(7'h40, 8'hdf, 3'h0, 8'h00);
    chk({7'h0, rh}, 8'h01);
    chk(rd, 8'h21);
    chk({4'h0, pg}, 8'h00);
    core.go(7'h01, 8'h00, 3'h0, 8'hd0);
    core.go(7'h40, 8'h0e, 3'h1, 8'h00);
    chk({7'h0, rh}, 8'h01);
    chk(rd, 8'he0);
    core.go(7'h40, 8'hc2, 3'h0, 8'h00);
    chk(pa, 8'he2);
    chk({7'h0, iv}, 8'h00);
    // page 10 does not exist; set 1 stays reachable
    core.go(7'h60, 8'hdf, 3'h0, 8'haa);
    core.go(7'h40, 8'hd0, 3'h0, 8'h00);
    chk({7'h0, iv}, 8'h00);
    chk({4'h0, pg}, 8'h00);
    core.go(7'h40, 8'h40, 3'h0, 8'h00);
    chk({7'h0, iv}, 8'h01);
    core.go(7'h40, 8'hc4, 3'h2, 8'h00);
    chk({7'h0, iv}, 8'h01);
    core.go(7'h60, 8'hdf, 3'h0, 8'h99);
    core.go(7'h40, 8'hc4, 3'h2, 8'h00);
    chk({7'h0, iv}, 8'h00);
    chk({4'h0, pg}, 8'h09);
    core.go(7'h60, 8'hdf, 3'h0, 8'hff);
    core.go(7'h40, 8'h40, 3'h0, 8'h00);
    chk({7'h0, iv}, 8'h00);
    chk({4'h0, pg}, 8'h0f);
    core.go(7'h40, 8'hc4, 3'h3, 8'h00);
    chk({7'h0, iv}, 8'h01);
    core.go(7'h40, 8'hd0, 3'h4, 8'h00);
    chk({5'h0, ar}, 8'h04);
    chk({7'h0, iv}, 8'h01);
    // reset in mid-run, with bank 1 and moved pointers
    core.go(7'h04, 8'h00, 3'h0, 8'h00);
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    chk(pp, 8'h00);
    chk(sa, 8'hc0);
    chk(sb, 8'hc8);
    chk({7'h0, bs}, 8'h00);
    chk({7'h0, v}, 8'h00);
    core.go(7'h40, 8'h06, 3'h1, 8'h00);
    chk(pa, 8'hc6);
    conclude();
  end
endmodule
